// ---- phy_basic_pkg.sv ----
// package with register map, field positions and reset values for the basic control/status pair
package phy_basic_pkg;
    // =====================================================================
    // register addresses
    localparam logic [4:0]  CTRL_ADDR        = 5'h00;
    localparam logic [4:0]  STAT_ADDR        = 5'h01;
    // =====================================================================
    // control field positions
    localparam int          CTRL_SW_RESET    = 15;
    localparam int          CTRL_LOOPBACK    = 14;
    localparam int          CTRL_SPEED_LSB   = 13;
    localparam int          CTRL_AN_EN       = 12;
    localparam int          CTRL_POWER_DOWN  = 11;
    localparam int          CTRL_ISOLATE     = 10;
    localparam int          CTRL_AN_RESTART  = 9;
    localparam int          CTRL_DUPLEX      = 8;
    localparam int          CTRL_COL_TEST    = 7;
    localparam int          CTRL_SPEED_MSB   = 6;
    localparam int          CTRL_UNIDIR      = 5;
    // writable bits 15..5; bits 4..0 reserved
    localparam logic [15:0] CTRL_WR_MASK     = 16'hFFE0;
    localparam logic [15:0] CTRL_RESET_VAL   = 16'h1040;
    // =====================================================================
    // status field positions
    localparam int          STAT_AN_DONE     = 5;
    localparam int          STAT_REM_FAULT   = 4;
    localparam int          STAT_LINK        = 2;
    localparam int          STAT_JABBER      = 1;
    // fixed bits: 14..11, 8, 7, 6, 3, 0 set
    localparam logic [15:0] STAT_FIXED       = 16'h79C9;
    // =====================================================================
    // forced speed codes {bit6, bit13}
    localparam logic [1:0]  SPEED_10         = 2'h0;
    localparam logic [1:0]  SPEED_100        = 2'h1;
    localparam logic [1:0]  SPEED_1000       = 2'h2;
    localparam logic [1:0]  SPEED_RSVD       = 2'h3;
endpackage

// ---- tx_gate.sv ----
// transmit-enable gate deciding whether MAC data may pass
`timescale 1ns/1ps
module tx_gate (
    // control inputs
    input  wire logic an_en,
    input  wire logic full_duplex,
    input  wire logic unidir,
    input  wire logic fiber_mode,
    input  wire logic link_ok,
    // result
    output logic      tx_allow
);
    logic uni_active;

    // unidir only counts with AN off, full duplex and fiber media
    assign uni_active = unidir && !an_en && full_duplex && fiber_mode;
    // without it, wait for a valid link
    assign tx_allow   = uni_active ? 1'b1 : link_ok;
endmodule

// ---- phy_basic_regs.sv ----
// basic control and status register pair with latched status flags and transmit gating
// =========================================================================
// Functional notes
// - ignore unidir when AN on or half duplex
// - unidir set: pass transmit data without link
// - unidir clear: pass transmit only with link
// - unidir only effective in fiber media modes
// - fixed capability bits 15..9 reported
// - status bit 8 reads one
// - status bit 7 reads one
// - preamble suppression reported by bit 6
// - remote fault latches high until read
// - link status latches low until read
// - jabber latches high until read
// - bits 3,0 one; bit 5 AN complete
// - speed field is {bit6, bit13}
`timescale 1ns/1ps
module phy_basic_regs #(
    parameter int ADDR_W = 5
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // management frame register access
    input  wire logic              management_frame_wr,
    input  wire logic              management_frame_rd,
    input  wire logic [ADDR_W-1:0] management_frame_addr,
    input  wire logic [15:0]       management_frame_wdata,
    output logic [15:0]            management_frame_rdata,
    output logic                   management_frame_rvalid,
    // live conditions from the port
    input  wire logic              link_up,
    input  wire logic              remote_fault,
    input  wire logic              jabber,
    input  wire logic              an_complete,
    input  wire logic              fiber_mode,
    // control outputs
    output logic                   tx_enable,
    output logic [1:0]             forced_speed,
    output logic                   full_duplex,
    output logic                   an_enable,
    output logic                   power_down,
    output logic                   loopback,
    output logic                   isolate,
    output logic                   an_restart,
    output logic                   collision_test
);
    // =====================================================================
    // elaboration check
    // refused at elaboration: an empty address bus cannot select a register
    if (ADDR_W < 1) begin : g_bad_addr_w
        $error("ADDR_W must be at least 1");
    end

    // =====================================================================
    // state
    typedef struct packed {
        logic [15:0] ctrl;
        logic        rf_hold;
        logic        link_hold;
        logic        jab_hold;
        logic [15:0] rdata;
        logic        rvalid;
        logic        tx_en;
        logic        an_restart;
    } regs_s;

    regs_s st_ff;
    regs_s nxt_st;
    logic  tx_allow;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] reg_addr);
        hit = (a == ADDR_W'(reg_addr));
    endfunction

    tx_gate u_tx_gate (
        .an_en       (st_ff.ctrl[phy_basic_pkg::CTRL_AN_EN]),
        .full_duplex (st_ff.ctrl[phy_basic_pkg::CTRL_DUPLEX]),
        .unidir      (st_ff.ctrl[phy_basic_pkg::CTRL_UNIDIR]),
        .fiber_mode  (fiber_mode),
        .link_ok     (link_up),
        .tx_allow    (tx_allow)
    );

    // =====================================================================
    // next state
    always_comb begin
        logic [15:0] status;
        status = '0;
        nxt_st = st_ff;
        nxt_st.rvalid = 1'b0;
        nxt_st.an_restart = 1'b0;
        nxt_st.tx_en = tx_allow;
        // fixed bits plus live and held flags
        status = phy_basic_pkg::STAT_FIXED;
        status[phy_basic_pkg::STAT_AN_DONE] = an_complete;
        status[phy_basic_pkg::STAT_REM_FAULT] = st_ff.rf_hold;
        status[phy_basic_pkg::STAT_LINK] = st_ff.link_hold;
        status[phy_basic_pkg::STAT_JABBER] = st_ff.jab_hold;
        // default: flags accumulate events
        nxt_st.rf_hold = st_ff.rf_hold | remote_fault;
        nxt_st.link_hold = st_ff.link_hold & link_up;
        nxt_st.jab_hold = st_ff.jab_hold | jabber;
        if (management_frame_rd) begin
            nxt_st.rvalid = 1'b1;
            if (hit(management_frame_addr, phy_basic_pkg::CTRL_ADDR)) begin
                nxt_st.rdata = st_ff.ctrl & phy_basic_pkg::CTRL_WR_MASK;
            end else if (hit(management_frame_addr, phy_basic_pkg::STAT_ADDR)) begin
                nxt_st.rdata = status;
                // read returns held value then refreshes to live
                nxt_st.rf_hold = remote_fault;
                nxt_st.link_hold = link_up;
                nxt_st.jab_hold = jabber;
            end else begin
                nxt_st.rdata = 16'h0000;
            end
        end
        if (management_frame_wr && hit(management_frame_addr, phy_basic_pkg::CTRL_ADDR)) begin
            nxt_st.ctrl = management_frame_wdata & phy_basic_pkg::CTRL_WR_MASK;
            // self-clearing bits: restart becomes a pulse, reset restores defaults
            nxt_st.an_restart = management_frame_wdata[phy_basic_pkg::CTRL_AN_RESTART];
            nxt_st.ctrl[phy_basic_pkg::CTRL_AN_RESTART] = 1'b0;
            if (management_frame_wdata[phy_basic_pkg::CTRL_SW_RESET]) begin
                nxt_st.ctrl = phy_basic_pkg::CTRL_RESET_VAL;
                nxt_st.an_restart = 1'b0;
            end
        end
    end

    // =====================================================================
    // registers; clock enable freezes everything
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{ctrl: phy_basic_pkg::CTRL_RESET_VAL, rf_hold: 1'b0, link_hold: 1'b0,
                       jab_hold: 1'b0, rdata: 16'h0000, rvalid: 1'b0, tx_en: 1'b0, an_restart: 1'b0};
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // =====================================================================
    // outputs
    assign management_frame_rdata  = st_ff.rdata;
    assign management_frame_rvalid = st_ff.rvalid;
    assign tx_enable      = st_ff.tx_en;
    // speed field msb from bit 6, lsb from bit 13
    assign forced_speed   = {st_ff.ctrl[phy_basic_pkg::CTRL_SPEED_MSB],
                             st_ff.ctrl[phy_basic_pkg::CTRL_SPEED_LSB]};
    assign full_duplex    = st_ff.ctrl[phy_basic_pkg::CTRL_DUPLEX];
    assign an_enable      = st_ff.ctrl[phy_basic_pkg::CTRL_AN_EN];
    assign power_down     = st_ff.ctrl[phy_basic_pkg::CTRL_POWER_DOWN];
    assign loopback       = st_ff.ctrl[phy_basic_pkg::CTRL_LOOPBACK];
    assign isolate        = st_ff.ctrl[phy_basic_pkg::CTRL_ISOLATE];
    assign an_restart     = st_ff.an_restart;
    assign collision_test = st_ff.ctrl[phy_basic_pkg::CTRL_COL_TEST];
endmodule

// ---- phy_basic_regs_properties.sv ----
// checker for the basic control/status register pair
`timescale 1ns/1ps
module phy_basic_regs_properties #(
    parameter int ADDR_W = 5
) (
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic              clk_en,
    input wire logic              management_frame_rd,
    input wire logic [ADDR_W-1:0] management_frame_addr,
    input wire logic [15:0]       management_frame_rdata,
    input wire logic              management_frame_rvalid,
    input wire logic              link_up,
    input wire logic              remote_fault,
    input wire logic              an_complete,
    input wire logic              fiber_mode,
    input wire logic              full_duplex,
    input wire logic              an_enable,
    input wire logic              tx_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic rd;
    logic rs;
    assign rd = management_frame_rd && clk_en;
    assign rs = rd && management_frame_addr == phy_basic_pkg::STAT_ADDR;
    read_answer_a: assert property (rd |=> management_frame_rvalid)
        else $error("read not answered");
    no_stray_a: assert property (!rd && clk_en |=> !management_frame_rvalid)
        else $error("answer without read");
    fixed_bits_a: assert property (rs |=> (management_frame_rdata & 16'hFFC9) == phy_basic_pkg::STAT_FIXED)
        else $error("fixed status bits wrong");
    an_done_a: assert property (rs |=> management_frame_rdata[5] == $past(an_complete))
        else $error("autoneg complete wrong");
    fault_latch_a: assert property (remote_fault && clk_en ##1 !rs ##1 rs |=> management_frame_rdata[4])
        else $error("remote fault not held");
    link_latch_a: assert property (!link_up && clk_en ##1 !rs ##1 rs |=> !management_frame_rdata[2])
        else $error("link loss not held");
    ctrl_reserved_a: assert property (rd && management_frame_addr == phy_basic_pkg::CTRL_ADDR
        |=> management_frame_rdata[4:0] == 5'h00) else $error("reserved bits nonzero");
    unmapped_zero_a: assert property (rd && management_frame_addr > 1 |=> management_frame_rdata == 16'h0000)
        else $error("unmapped read nonzero");
    tx_link_a: assert property ((an_enable || !full_duplex || !fiber_mode) && clk_en
        |=> tx_enable == $past(link_up)) else $error("transmit gate ignores link");
endmodule
bind phy_basic_regs phy_basic_regs_properties #(.ADDR_W(ADDR_W)) chk (.clock(clock), .rst_n(rst_n),
    .clk_en(clk_en), .management_frame_rd(management_frame_rd), .management_frame_addr(management_frame_addr),
    .management_frame_rdata(management_frame_rdata), .management_frame_rvalid(management_frame_rvalid),
    .link_up(link_up), .remote_fault(remote_fault), .an_complete(an_complete), .fiber_mode(fiber_mode),
    .full_duplex(full_duplex), .an_enable(an_enable), .tx_enable(tx_enable));

// ---- mgmt_station.sv ----
// station management model issuing register frames
`timescale 1ns/1ps
module mgmt_station (
    input wire logic        clock,
    output logic            wr,
    output logic            rd,
    output logic [4:0]      addr,
    output logic [15:0]     wdata,
    input wire logic [15:0] rdata,
    input wire logic        rvalid
);
    // frames carry no preamble; no macsec or eee here, so half duplex is legal
    // forced 1000 and its relink power-down are never requested by this model
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 5'h1F;
        wdata = 16'h0000;
    end
    // released lines show the inverse so stale values cannot pass
    task automatic put(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic get(input logic [4:0] a, output logic [15:0] d, output logic ok);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
        ok = rvalid;
    endtask
endmodule

// ---- phy_basic_regs_tb.sv ----
// self-checking testbench for the basic control/status pair
`timescale 1ns/1ps
module phy_basic_regs_tb;
    logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, link_up = 1'b1, remote_fault = 1'b0;
    logic jabber = 1'b0, an_complete = 1'b0, fiber_mode = 1'b1;
    logic wr, rd, ok, rvalid, tx_enable;
    logic full_duplex, an_enable, power_down, loopback, isolate, an_restart, collision_test;
    logic [1:0]  forced_speed;
    logic [4:0]  addr;
    logic [15:0] wdata, rdata, got;
    logic [15:0] tx_ctl [5] = '{16'h0120, 16'h0100, 16'h1120, 16'h0020, 16'h0120};
    logic [4:0]  tx_fib = 5'h0F;
    logic [4:0]  tx_exp = 5'h01;
    int num_errors = 0;
    int cmp_count = 0;
    always #2 clock = ~clock;
    mgmt_station host (.clock(clock), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid));
    phy_basic_regs dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .management_frame_wr(wr),
        .management_frame_rd(rd), .management_frame_addr(addr), .management_frame_wdata(wdata),
        .management_frame_rdata(rdata), .management_frame_rvalid(rvalid), .link_up(link_up),
        .remote_fault(remote_fault), .jabber(jabber), .an_complete(an_complete), .fiber_mode(fiber_mode),
        .tx_enable(tx_enable), .forced_speed(forced_speed), .full_duplex(full_duplex), .an_enable(an_enable),
        .power_down(power_down), .loopback(loopback), .isolate(isolate), .an_restart(an_restart),
        .collision_test(collision_test));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [15:0] e);
        host.get(a, got, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk(got, e);
    endtask
    task automatic give_verdict();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        rchk(5'h00, 16'h1040);
        rchk(5'h01, 16'h79C9);
        rchk(5'h01, 16'h79CD);
        $display("test reset done");
        host.put(5'h00, 16'h7FFF);
        #1;
        chk({7'h00, forced_speed, full_duplex, an_enable, power_down, loopback, isolate, an_restart,
             collision_test}, 16'h01FF);
        rchk(5'h00, 16'h7DE0);
        host.put(5'h00, 16'h8000);
        #1;
        chk({7'h00, forced_speed, full_duplex, an_enable, power_down, loopback, isolate, an_restart,
             collision_test}, 16'h0120);
        rchk(5'h00, 16'h1040);
        host.put(5'h02, 16'hFFFF);
        rchk(5'h02, 16'h0000);
        $display("test control done");
        @(posedge clock);
        link_up <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            @(posedge clock);
            fiber_mode <= tx_fib[i];
            host.put(5'h00, tx_ctl[i]);
            repeat (3) @(posedge clock);
            #1;
            chk({15'h0000, tx_enable}, {15'h0000, tx_exp[i]});
        end
        $display("test transmit gate done");
        @(posedge clock);
        an_complete <= 1'b1;
        remote_fault <= 1'b1;
        jabber <= 1'b1;
        @(posedge clock);
        remote_fault <= 1'b0;
        jabber <= 1'b0;
        link_up <= 1'b1;
        rchk(5'h01, 16'h79FB);
        rchk(5'h01, 16'h79ED);
        @(posedge clock);
        clk_en <= 1'b0;
        jabber <= 1'b1;
        @(posedge clock);
        clk_en <= 1'b1;
        jabber <= 1'b0;
        rchk(5'h01, 16'h79ED);
        $display("test status latches done");
        give_verdict();
    end
    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end
endmodule
